// ==== rtl/blit_pkg.sv ====
package blit_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_OFS  = 16'h8000;
    localparam logic [15:0] STAT_OFS  = 16'h8004;
    localparam logic [15:0] OPER_OFS  = 16'h8008;
    localparam logic [15:0] SRC_OFS   = 16'h800c;
    localparam logic [15:0] DST_OFS   = 16'h8010;
    localparam logic [15:0] PITCH_OFS = 16'h8014;
    localparam logic [15:0] WID_OFS   = 16'h8018;
    localparam logic [15:0] HGT_OFS   = 16'h801c;
    localparam logic [15:0] TCOL_OFS  = 16'h8020;
    // haddr bit that selects the pixel data area
    localparam int          DATA_AREA_BIT = 16;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_DLIN_BIT  = 16;
    localparam int CTRL_SLIN_BIT  = 17;
    localparam int CTRL_BPP_BIT   = 18;
    localparam int STAT_ACT_BIT   = 0;
    localparam int STAT_FULL_BIT  = 4;
    localparam int STAT_HALF_BIT  = 5;
    localparam int STAT_NEMP_BIT  = 6;
    localparam int OP_LSB         = 0;

    // ------------------------------------------------------------
    // operation codes, sizes, reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  OP_TWRITE      = 4'h4;
    localparam logic [3:0]  OP_TMOVE       = 4'h5;
    localparam int          FIFO_DEPTH_DEF = 16;
    localparam int          DIM_W_DEF      = 10;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_RD_WAIT, ST_TEST, ST_WR_WAIT, ST_ADVANCE
    } eng_state_t;

    // request towards the display buffer
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
    } mem_req_t;

endpackage : blit_pkg

// ==== rtl/transparent_blit_engine.sv ====
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps

// Overview of operation
// - every 16-bit word written to the data area during a transparent write counts as one received word
// - source address bit 0 holds the phase of a transparent write
// - operation code 4 selects the transparent write from the host
// - operation code 5 selects the transparent move, positive direction
// - transparent colour register: 8-bit index or 16-bit pixel
// - control bit 18 picks 8 bpp (0) or 16 bpp (1)
// - line pitch is counted in 16-bit words
// - linear-select bit clear makes that area rectangular using the pitch
// - start bit launches; status bit 0 shows active; host waits for it
// - 8 bpp write expects ((width+1+phase)/2) times height words
// - status shows fifo full bit 4, half bit 5, not empty bit 6
// - move source and destination are each rectangular or linear
// - source pixels equal to the transparent colour are not written
// - move walks upward from the upper-left addresses only
// - destination address is the byte address of the upper-left pixel
// - move source address is the byte address of the upper-left pixel
// - a write stays active until all expected words have arrived
// - phase 1 takes each row's first pixel from the upper byte
// - transparent write applies no raster operation
module transparent_blit_engine
    import blit_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH_DEF,
    parameter int DW    = DIM_W_DEF
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // display buffer port
    output mem_req_t         mem_o,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_HALF = (AW+1)'(DEPTH / 2);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   bpp16;
        logic                   dlin;
        logic                   slin;
        logic [3:0]             op;
        logic [31:0]            src;
        logic [31:0]            dst;
        logic [15:0]            pitch;
        logic [DW-1:0]          wid;
        logic [DW-1:0]          hgt;
        logic [15:0]            tcol;
        logic                   ap_valid;
        logic                   ap_write;
        logic                   ap_data;
        logic                   ap_word;
        logic                   ap_lane;
        logic [15:0]            ap_addr;
        logic [31:0]            rdata;
        logic [DEPTH-1:0][15:0] fifo;
        logic [AW-1:0]          wp;
        logic [AW-1:0]          rp;
        logic [AW:0]            cnt;
        eng_state_t             st;
        logic                   active;
        logic [DW-1:0]          x;
        logic [DW-1:0]          y;
        logic [31:0]            s_ptr;
        logic [31:0]            s_row;
        logic [31:0]            d_ptr;
        logic [31:0]            d_row;
        logic [15:0]            word;
        logic                   have_word;
        logic                   byte_sel;
        logic [15:0]            pix;
        logic [31:0]            rx;
        logic [31:0]            expect_words;
        mem_req_t               mem;
    } state_t;

    state_t q;
    state_t n;

    logic        stall;
    logic [AW+1:0] need;

    assign need  = q.ap_word ? (AW+2)'(2) : (AW+2)'(1);
    assign stall = q.ap_valid & q.ap_write & q.ap_data &
                   (({1'b0, q.cnt} + need) > (AW+2)'(DEPTH));

    assign hreadyout = ~stall;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;
    assign mem_o     = q.mem;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] step;
        logic [31:0] s_next;
        logic [31:0] d_next;
        logic        transp;
        logic [15:0] hw;
        n      = q;
        step   = q.bpp16 ? 32'd2 : 32'd1;
        s_next = q.slin ? q.s_ptr + step
                        : q.s_row + {15'd0, q.pitch, 1'b0};
        d_next = q.dlin ? q.d_ptr + step
                        : q.d_row + {15'd0, q.pitch, 1'b0};
        transp = q.bpp16 ? (q.pix == q.tcol)
                         : (q.pix[7:0] == q.tcol[7:0]);
        hw     = q.ap_lane ? hwdata[31:16] : hwdata[15:0];

        // engine walk
        unique case (q.st)
            ST_IDLE: begin
                n.active = 1'b0;
            end
            ST_FETCH: begin
                if (q.op == OP_TMOVE) begin
                    n.mem.req  = 1'b1;
                    n.mem.we   = 1'b0;
                    n.mem.addr = {q.s_ptr[31:1], 1'b0};
                    n.mem.be   = 2'b11;
                    n.st       = ST_RD_WAIT;
                end else if (q.bpp16) begin
                    if (q.cnt != '0) begin
                        n.pix = q.fifo[q.rp];
                        n.rp  = q.rp + 1'b1;
                        n.cnt = q.cnt - 1'b1;
                        n.st  = ST_TEST;
                    end
                end else if (q.have_word) begin
                    n.pix = {8'd0, q.byte_sel ? q.word[15:8]
                                              : q.word[7:0]};
                    n.st  = ST_TEST;
                end else if (q.cnt != '0) begin
                    n.word      = q.fifo[q.rp];
                    n.rp        = q.rp + 1'b1;
                    n.cnt       = q.cnt - 1'b1;
                    n.have_word = 1'b1;
                    // phase applies to the first word of each row
                    n.byte_sel  = (q.x == '0) ? q.src[0] : 1'b0;
                end
            end
            ST_RD_WAIT: begin
                if (mem_ack) begin
                    n.mem.req = 1'b0;
                    n.pix = q.bpp16 ? mem_rdata
                          : {8'd0, q.s_ptr[0] ? mem_rdata[15:8]
                                              : mem_rdata[7:0]};
                    n.st  = ST_TEST;
                end
            end
            ST_TEST: begin
                if (transp) begin
                    n.st = ST_ADVANCE;
                end else begin
                    // pixel goes out as is, no raster operation
                    n.mem.req   = 1'b1;
                    n.mem.we    = 1'b1;
                    n.mem.addr  = {q.d_ptr[31:1], 1'b0};
                    n.mem.wdata = q.bpp16 ? q.pix
                                          : {q.pix[7:0], q.pix[7:0]};
                    n.mem.be    = q.bpp16 ? 2'b11
                                : (q.d_ptr[0] ? 2'b10 : 2'b01);
                    n.st        = ST_WR_WAIT;
                end
            end
            ST_WR_WAIT: begin
                if (mem_ack) begin
                    n.mem.req = 1'b0;
                    n.mem.we  = 1'b0;
                    n.st      = ST_ADVANCE;
                end
            end
            ST_ADVANCE: begin
                if (!q.bpp16) begin
                    if (q.byte_sel || q.x == q.wid) begin
                        n.have_word = 1'b0;
                    end else begin
                        n.byte_sel = 1'b1;
                    end
                end
                if (q.x != q.wid) begin
                    n.x     = q.x + 1'b1;
                    n.s_ptr = q.s_ptr + step;
                    n.d_ptr = q.d_ptr + step;
                    n.st    = ST_FETCH;
                end else if (q.y != q.hgt) begin
                    n.x     = '0;
                    n.y     = q.y + 1'b1;
                    n.s_ptr = s_next;
                    n.s_row = s_next;
                    n.d_ptr = d_next;
                    n.d_row = d_next;
                    n.st    = ST_FETCH;
                end else if (q.op != OP_TWRITE ||
                             q.rx >= q.expect_words) begin
                    n.st     = ST_IDLE;
                    n.active = 1'b0;
                end
            end
        endcase

        // ahb data phase
        if (q.ap_valid && q.ap_write && !stall) begin
            if (q.ap_data) begin
                // words outside a transparent write are dropped
                if (q.active && q.op == OP_TWRITE) begin
                    n.fifo[n.wp] = q.ap_word ? hwdata[15:0] : hw;
                    n.wp         = n.wp + 1'b1;
                    n.cnt        = n.cnt + 1'b1;
                    n.rx         = n.rx + 32'd1;
                    if (q.ap_word) begin
                        n.fifo[n.wp] = hwdata[31:16];
                        n.wp         = n.wp + 1'b1;
                        n.cnt        = n.cnt + 1'b1;
                        n.rx         = n.rx + 32'd1;
                    end
                end
            end else begin
                unique case (q.ap_addr)
                    CTRL_OFS: begin
                        n.bpp16 = hwdata[CTRL_BPP_BIT];
                        n.dlin  = hwdata[CTRL_DLIN_BIT];
                        n.slin  = hwdata[CTRL_SLIN_BIT];
                        if (hwdata[CTRL_START_BIT] && !q.active &&
                            (q.op == OP_TWRITE || q.op == OP_TMOVE)) begin
                            n.active    = 1'b1;
                            n.st        = ST_FETCH;
                            n.x         = '0;
                            n.y         = '0;
                            n.s_ptr     = q.src;
                            n.s_row     = q.src;
                            n.d_ptr     = q.dst;
                            n.d_row     = q.dst;
                            n.have_word = 1'b0;
                            n.byte_sel  = 1'b0;
                            n.rx        = '0;
                            n.expect_words = hwdata[CTRL_BPP_BIT]
                                ? (32'(q.wid) + 32'd1) * (32'(q.hgt) + 32'd1)
                                : ((32'(q.wid) + 32'd2 + 32'(q.src[0]))
                                   >> 1) * (32'(q.hgt) + 32'd1);
                        end
                    end
                    OPER_OFS:  n.op    = hwdata[OP_LSB +: 4];
                    SRC_OFS:   n.src   = hwdata;
                    DST_OFS:   n.dst   = hwdata;
                    PITCH_OFS: n.pitch = hwdata[15:0];
                    WID_OFS:   n.wid   = hwdata[DW-1:0];
                    HGT_OFS:   n.hgt   = hwdata[DW-1:0];
                    TCOL_OFS:  n.tcol  = hwdata[15:0];
                    default: ;
                endcase
            end
        end

        // ahb address phase
        if (!stall) begin
            n.ap_valid = hsel & htrans[1] & hready;
            n.ap_write = hwrite;
            n.ap_data  = haddr[DATA_AREA_BIT];
            n.ap_word  = (hsize == HSIZE_WORD);
            n.ap_lane  = haddr[1];
            n.ap_addr  = haddr[15:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                n.rdata = '0;
                if (!haddr[DATA_AREA_BIT]) begin
                    unique case (haddr[15:0])
                        CTRL_OFS: begin
                            n.rdata[CTRL_START_BIT] = n.active;
                            n.rdata[CTRL_DLIN_BIT]  = n.dlin;
                            n.rdata[CTRL_SLIN_BIT]  = n.slin;
                            n.rdata[CTRL_BPP_BIT]   = n.bpp16;
                        end
                        STAT_OFS: begin
                            n.rdata[STAT_ACT_BIT]  = n.active;
                            n.rdata[STAT_FULL_BIT] = (n.cnt == CNT_FULL);
                            n.rdata[STAT_HALF_BIT] = (n.cnt >= CNT_HALF);
                            n.rdata[STAT_NEMP_BIT] = (n.cnt != '0);
                        end
                        OPER_OFS:  n.rdata[3:0]    = n.op;
                        SRC_OFS:   n.rdata         = n.src;
                        DST_OFS:   n.rdata         = n.dst;
                        PITCH_OFS: n.rdata[15:0]   = n.pitch;
                        WID_OFS:   n.rdata[DW-1:0] = n.wid;
                        HGT_OFS:   n.rdata[DW-1:0] = n.hgt;
                        TCOL_OFS:  n.rdata[15:0]   = n.tcol;
                        default: ;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule : transparent_blit_engine

// ==== bench/blit_checker.sv ====
`timescale 1ns/10ps
module blit_checker
    import blit_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH_DEF,
    parameter int DW    = DIM_W_DEF
) (
    // ahb side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // display buffer side
    input wire mem_req_t    mem_o,
    input wire logic        mem_ack,
    input wire logic [15:0] mem_rdata
);
    // ----------------------------------------
    // setup register shadows
    // ----------------------------------------
    logic        wph_q;
    logic        wide_q;
    logic [15:0] wadr_q;
    logic [15:0] tcol_q;
    logic [15:0] dst_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_q  <= 1'b0;
            wide_q <= 1'b0;
            wadr_q <= 16'h0000;
            tcol_q <= 16'h0000;
            dst_q  <= 16'h0000;
        end else if (hready) begin
            wph_q  <= hsel && htrans[1] && hwrite && !haddr[DATA_AREA_BIT];
            wadr_q <= haddr[15:0];
            if (wph_q && wadr_q == CTRL_OFS)
                wide_q <= hwdata[CTRL_BPP_BIT];
            if (wph_q && wadr_q == TCOL_OFS)
                tcol_q <= hwdata[15:0];
            if (wph_q && wadr_q == DST_OFS)
                dst_q <= hwdata[15:0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wait; mem_o.req && !mem_ack; endsequence
    sequence s_done; mem_o.req && mem_ack; endsequence
    sequence s_pwr;  mem_o.req && mem_o.we; endsequence
    a_req_held: assert property (s_wait |=> mem_o.req && $stable(mem_o))
        else $error("memory request changed before ack");
    a_req_drop: assert property (s_done |=> !mem_o.req)
        else $error("memory request held after ack");
    a_addr_even: assert property (mem_o.req |-> !mem_o.addr[0])
        else $error("odd memory address");
    a_be_wide: assert property (s_pwr and wide_q |-> mem_o.be == 2'b11)
        else $error("wide pixel not written whole");
    a_be_byte: assert property (s_pwr and !wide_q |->
        mem_o.be inside {2'b01, 2'b10} && mem_o.wdata[15:8] == mem_o.wdata[7:0])
        else $error("byte pixel lanes wrong");
    a_skip_wide: assert property (s_pwr and wide_q |->
        mem_o.wdata != tcol_q) else $error("transparent pixel written");
    a_skip_byte: assert property (s_pwr and !wide_q |->
        mem_o.wdata[7:0] != tcol_q[7:0]) else $error("transparent byte written");
    a_dst_upward: assert property (s_pwr |->
        mem_o.addr >= 32'({dst_q[15:1], 1'b0})) else $error("write below start");
    a_reg_nowait: assert property (hsel && htrans[1] && hready &&
        !haddr[DATA_AREA_BIT] |=> hreadyout) else $error("register wait state");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
endmodule : blit_checker

bind transparent_blit_engine blit_checker #(.DEPTH(DEPTH), .DW(DW)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mem_o(mem_o), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

// ==== bench/disp_mem_model.sv ====
`timescale 1ns/10ps
module disp_mem_model
    import blit_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // request side
    input  wire mem_req_t    mem_o,
    input  wire logic [7:0]  lat,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] cnt_q;
    int         a;
    assign a = int'(mem_o.addr[11:0]);
    // read data toggles outside the ack cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack   <= 1'b0;
            cnt_q     <= 8'h00;
            mem_rdata <= 16'h5a5a;
        end else if (mem_o.req && !mem_ack && cnt_q >= lat) begin
            mem_ack   <= 1'b1;
            cnt_q     <= 8'h00;
            mem_rdata <= {mem[a + 1], mem[a]};
            if (mem_o.we && mem_o.be[0])
                mem[a] <= mem_o.wdata[7:0];
            if (mem_o.we && mem_o.be[1])
                mem[a + 1] <= mem_o.wdata[15:8];
        end else begin
            mem_ack   <= 1'b0;
            cnt_q     <= mem_o.req ? cnt_q + 8'h01 : 8'h00;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : disp_mem_model

// ==== bench/tb_transparent_blit_engine.sv ====
`timescale 1ns/10ps
module tb_transparent_blit_engine;
    import blit_pkg::*;
    localparam logic [31:0] DATA_A = 32'h0001_0000;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_ack;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] mem_rdata;
    logic [7:0]  lat;
    mem_req_t    mem_o;
    int          num_errors = 0, comparisons = 0, cyc = 0;

    transparent_blit_engine #(.DEPTH(16), .DW(10)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .mem_o(mem_o), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    disp_mem_model dmem (.hclk(hclk), .hresetn(hresetn), .mem_o(mem_o),
        .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [2:0] sz, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] t;
        xfer({16'h0000, a}, 1'b1, HSIZE_WORD, d, t);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        xfer({16'h0000, a}, 1'b0, HSIZE_WORD, 32'h0000_0000, d);
    endtask : rd
    task automatic setup(input int s, d, w, h, op, tc, ctl);
        wr(SRC_OFS, 32'(s));
        wr(DST_OFS, 32'(d));
        wr(PITCH_OFS, 32'h0000_0008);
        wr(WID_OFS, 32'(w - 1));
        wr(HGT_OFS, 32'(h - 1));
        wr(OPER_OFS, 32'(op));
        wr(TCOL_OFS, 32'(tc));
        wr(CTRL_OFS, 32'(ctl) | 32'h0000_0001);
    endtask : setup
    task automatic wait_idle();
        logic [31:0] s;
        int          i;
        s = 32'h0000_0001;
        i = 0;
        while (s[STAT_ACT_BIT] !== 1'b0 && i < 2000) begin
            rd(STAT_OFS, s);
            i++;
        end
        check(s[STAT_ACT_BIT], 1'b0);
    endtask : wait_idle
    task automatic fill();
        for (int i = 0; i < 4096; i++)
            dmem.mem[i] = 8'hee;
    endtask : fill
    // every third pixel transparent, some share its low byte
    function automatic logic [15:0] pix(int r, c, logic [15:0] tc, bit b16);
        if ((r + c) % 3 == 2)
            return tc;
        if (b16 && (r + c) % 3 == 1)
            return tc ^ 16'h0100;
        return 16'(r * 32 + c + 1);
    endfunction : pix
    function automatic int adr(int base, bit lin, int r, c, w, bp);
        return lin ? base + (r * w + c) * bp : base + r * 16 + c * bp;
    endfunction : adr
    function automatic logic [15:0] got(int a, bit b16);
        return {b16 ? dmem.mem[a + 1] : 8'h00, dmem.mem[a]};
    endfunction : got
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] v;
        for (int i = 0; i < 9; i++) begin
            rd(CTRL_OFS + 16'(4 * i), v);
            check(v, REG_RESET);
        end
        for (int i = 2; i < 9; i++) begin
            wr(CTRL_OFS + 16'(4 * i), 32'(i));
            rd(CTRL_OFS + 16'(4 * i), v);
            check(v, 32'(i));
        end
        wr(STAT_OFS, 32'hffff_ffff);
        rd(STAT_OFS, v);
        check(v, 32'h0000_0000);
        wr(16'h8040, 32'h1234_5678);
        rd(16'h8040, v);
        check(v, 32'h0000_0000);
        $display("registers done");
    endtask : t_regs
    task automatic t_bad_ops();
        logic [31:0] v;
        for (int op = 0; op < 16; op++) begin
            if (op == 4 || op == 5)
                continue;
            wr(OPER_OFS, 32'(op));
            wr(CTRL_OFS, 32'h0000_0001);
            rd(STAT_OFS, v);
            check(v[STAT_ACT_BIT], 1'b0);
        end
        $display("operation codes done");
    endtask : t_bad_ops
    task automatic twrite(input bit b16, ph, dw, input int w, h, dst);
        logic [15:0] q[$];
        logic [15:0] tc, b, e;
        logic [31:0] v, a;
        logic [7:0]  lo;
        int          k;
        tc = b16 ? 16'h127c : 16'h007c;
        e = b16 ? 16'heeee : 16'h00ee;
        fill();
        setup(ph, dst, w, h, OP_TWRITE, tc, int'(b16) << CTRL_BPP_BIT);
        rd(STAT_OFS, v);
        check(v[6:0], 7'h01);
        for (int r = 0; r < h; r++) begin
            if (b16)
                for (int c = 0; c < w; c++)
                    q.push_back(pix(r, c, tc, 1));
            else
                for (int c = -int'(ph); c < w; c += 2) begin
                    lo = c < 0 ? 8'h55 : 8'(pix(r, c, tc, 0));
                    q.push_back({8'(pix(r, c + 1, tc, 0)), lo});
                end
        end
        k = 0;
        while (k < q.size()) begin
            if (k + 2 >= q.size()) begin
                rd(STAT_OFS, v);
                check(v[STAT_ACT_BIT], 1'b1);
            end
            if (k == 17) begin
                rd(STAT_OFS, v);
                check(v[6:4], 3'b111);
            end
            if (dw && k + 1 < q.size() && k < 16) begin
                xfer(DATA_A, 1'b1, HSIZE_WORD, {q[k + 1], q[k]}, v);
                k += 2;
            end else begin
                a = DATA_A | 32'(k % 2 * 2);
                xfer(a, 1'b1, 3'h1, {q[k], q[k]}, v);
                k++;
            end
        end
        wait_idle();
        check(dmem.mem[dst - 1], 8'hee);
        for (int r = 0; r < h; r++)
            for (int c = 0; c < w; c++) begin
                b = pix(r, c, tc, b16);
                k = adr(dst, 0, r, c, w, b16 ? 2 : 1);
                check(got(k, b16), b == tc ? e : b);
            end
        $display("transparent write done");
    endtask : twrite
    task automatic tmove(input bit b16, dl, sl, input int s, d);
        logic [15:0] tc, b, e;
        int          bp, a;
        tc = b16 ? 16'h127c : 16'h007c;
        e = b16 ? 16'heeee : 16'h00ee;
        bp = b16 ? 2 : 1;
        fill();
        for (int r = 0; r < 3; r++)
            for (int c = 0; c < 4; c++) begin
                b = pix(r, c, tc, b16);
                a = adr(s, sl, r, c, 4, bp);
                dmem.mem[a] = b[7:0];
                if (b16)
                    dmem.mem[a + 1] = b[15:8];
            end
        a = int'(b16) << CTRL_BPP_BIT | int'(sl) << CTRL_SLIN_BIT;
        setup(s, d, 4, 3, OP_TMOVE, tc, a | int'(dl) << CTRL_DLIN_BIT);
        wait_idle();
        for (int r = 0; r < 3; r++)
            for (int c = 0; c < 4; c++) begin
                b = pix(r, c, tc, b16);
                a = adr(d, dl, r, c, 4, bp);
                check(got(a, b16), b == tc ? e : b);
            end
        $display("transparent move done");
    endtask : tmove
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
        lat = 8'h01;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_bad_ops();
        twrite(0, 0, 1, 5, 2, 16'h0101);
        lat <= 8'h03;
        twrite(0, 1, 0, 6, 2, 16'h0120);
        lat <= 8'h64;
        twrite(1, 0, 1, 24, 1, 16'h0400);
        lat <= 8'h02;
        tmove(0, 1, 0, 16'h0203, 16'h0400);
        lat <= 8'h00;
        tmove(1, 0, 1, 16'h0600, 16'h0302);
        tally_and_finish();
    end
endmodule : tb_transparent_blit_engine
